/* src/scts_sequencer.sv */
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`include "scts_cfg.svh"
// How it works
// - Step edge starts scan, then advances
// - Step edges ignored until channel-made pulse
// - Abort edge stops scan, opens relays
// - Made pulse of configured width per close
// - Pulse ends early when relay opens
// - Init opens relays, made output off
// - Init pulse width five ms, saveable
// - Init empties list, step source, zero delay
// - Init filter off, fifty ms, saveable
// - Init command keeps communication settings
// - Saveables persist only after save command
// - Communication settings stored automatically
// - Step on last channel ends scan
// - After abort, restart from first channel
// - Pulse width clamped to 1..100 ms
module scts_sequencer #(
    parameter int TICK_CYC = `SCTS_TICK_CYC,
    parameter int LIST_AW = 6,
    parameter int CH_W = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic step_in,
    input wire logic abort_in,
    output logic made_out,
    output logic relay_on,
    output logic [CH_W-1:0] relay_chan,
    output logic bus_relay_on,
    output logic scan_active,
    output logic nv_wr,
    output logic [3:0] nv_wr_addr,
    output logic [31:0] nv_wr_data,
    input wire logic nv_ld,
    input wire logic [3:0] nv_ld_addr,
    input wire logic [31:0] nv_ld_data
);
    import scts_pkg::*;

    localparam int TW = $clog2(TICK_CYC + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);
    scts_state_t state_r, state_nxt;
    logic ack_r, fen_r, src_r, made_r, relay_r, sv_r, pend_r;
    logic [7:0] pulse_r, pc_r;
    logic [13:0] delay_r, tmr_r;
    logic [15:0] fms_r;
    logic [LIST_AW:0] len_r;
    logic [LIST_AW-1:0] laddr_r, idx_r, idx_nxt;
    logic [31:0] comm_r;
    logic [TW-1:0] div_r;
    logic [2:0] sv_i_r;
    logic [CH_W-1:0] mem_rd;
    wire [1:0] edge_v;

    // One wait cycle: the answer comes at the second edge of a request
    wire req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    wire wr_acc = avs_write & ack_r;
    wire rd_start = avs_read & ~ack_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Command decode
    wire hit_ctrl = wr_acc & (avs_address == `SCTS_OFS_CTRL);
    wire soft_trg = hit_ctrl & avs_writedata[`SCTS_CTRL_TRG];
    wire soft_abort = hit_ctrl & avs_writedata[`SCTS_CTRL_ABORT];
    wire init_cmd = hit_ctrl & avs_writedata[`SCTS_CTRL_INIT];
    wire save_cmd = hit_ctrl & avs_writedata[`SCTS_CTRL_SAVE];
    wire busy = (state_r != SCTS_IDLE);

    // Bus writes to settings other than communication are frozen while scanning; the restore port always wins the cycle
    wire cfg_wr = nv_ld | (wr_acc & ~busy);
    wire [3:0] cfg_sel = nv_ld ? nv_ld_addr : avs_address;
    wire [31:0] cfg_wd = nv_ld ? nv_ld_data : avs_writedata;
    wire we_pulse = cfg_wr & (cfg_sel == `SCTS_OFS_PULSE);
    wire we_delay = cfg_wr & (cfg_sel == `SCTS_OFS_DELAY);
    wire we_filt = cfg_wr & (cfg_sel == `SCTS_OFS_FILT);
    wire we_src = cfg_wr & (cfg_sel == `SCTS_OFS_SRC);
    wire we_len = cfg_wr & (cfg_sel == `SCTS_OFS_LEN);
    wire we_laddr = cfg_wr & (cfg_sel == `SCTS_OFS_LADDR);
    wire we_ldata = cfg_wr & (cfg_sel == `SCTS_OFS_LDATA);
    wire comm_bus = wr_acc & ~nv_ld & (avs_address == `SCTS_OFS_COMM);
    wire we_comm = comm_bus | (nv_ld & (nv_ld_addr == `SCTS_OFS_COMM));

    wire [15:0] pw_in = cfg_wd[15:0];
    wire pw_lo = pw_in < 16'(`SCTS_PULSE_MIN);
    wire pw_hi = pw_in > 16'(`SCTS_PULSE_MAX);
    wire [7:0] pulse_in = pw_lo ? `SCTS_PULSE_MIN : (pw_hi ? `SCTS_PULSE_MAX : pw_in[7:0]);
    wire [13:0] delay_in = (cfg_wd[15:0] > 16'(`SCTS_DELAY_MAX)) ? `SCTS_DELAY_MAX : cfg_wd[13:0];
    wire len_big = cfg_wd[15:0] > 16'(1 << LIST_AW);
    wire [LIST_AW:0] len_in = len_big ? (LIST_AW+1)'(1 << LIST_AW) : cfg_wd[LIST_AW:0];

    // Defaults apply at reset and on the init command, except communication
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_r <= `SCTS_PULSE_RST;
            delay_r <= `SCTS_DELAY_RST;
            src_r <= `SCTS_SRC_STEP;
            len_r <= '0;
            laddr_r <= '0;
            fen_r <= `SCTS_FILT_EN_RST;
            fms_r <= `SCTS_FILT_MS_RST;
        end else begin
            if (init_cmd || we_pulse) pulse_r <= init_cmd ? `SCTS_PULSE_RST : pulse_in;
            if (init_cmd || we_delay) delay_r <= init_cmd ? `SCTS_DELAY_RST : delay_in;
            if (init_cmd || we_src) src_r <= init_cmd ? `SCTS_SRC_STEP : cfg_wd[0];
            if (init_cmd || we_len) len_r <= init_cmd ? '0 : len_in;
            if (init_cmd) laddr_r <= '0;
            else if (we_laddr) laddr_r <= cfg_wd[LIST_AW-1:0];
            else if (we_ldata) laddr_r <= laddr_r + 1'b1;
            if (init_cmd || we_filt) fen_r <= init_cmd ? `SCTS_FILT_EN_RST : cfg_wd[`SCTS_FILT_EN];
            if (init_cmd || we_filt) fms_r <= init_cmd ? `SCTS_FILT_MS_RST : cfg_wd[`SCTS_FILT_MS_LSB +: 16];
        end
    end

    // Not touched by the init command
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            comm_r <= `SCTS_COMM_RST;
        end else if (we_comm) begin
            comm_r <= cfg_wd;
        end
    end

    // Millisecond timebase, restarted on every state change so intervals are exact
    wire st_chg = (state_nxt != state_r);
    wire tick = (div_r == TICK_LAST);
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_r <= '0;
        end else if (st_chg || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Input conditioning; the optional filter demands a stable level for the filter time
    wire [1:0] pin_v = {abort_in, step_in};
    generate
        for (genvar g = 0; g < 2; g++) begin : g_in
            logic s1_r, s2_r, flt_r, prv_r;
            logic [15:0] fc_r;
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    prv_r <= 1'b0;
                end else begin
                    s1_r <= pin_v[g];
                    s2_r <= s1_r;
                    prv_r <= flt_r;
                end
            end
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    flt_r <= 1'b0;
                    fc_r <= '0;
                end else if (s2_r == flt_r) begin
                    fc_r <= '0;
                end else if (!fen_r || fc_r >= fms_r) begin
                    flt_r <= s2_r;
                    fc_r <= '0;
                end else if (tick) begin
                    fc_r <= fc_r + 16'h0001;
                end
            end
            assign edge_v[g] = flt_r & ~prv_r;
        end
    endgenerate

    wire step_evt = (edge_v[0] | soft_trg) & (src_r == `SCTS_SRC_STEP);
    wire abort_evt = edge_v[1] | soft_abort | init_cmd;
    wire at_last = ({1'b0, idx_r} == len_r - 1'b1);

    always_comb begin
        state_nxt = state_r;
        idx_nxt = idx_r;
        if (abort_evt) begin
            state_nxt = SCTS_IDLE;
            idx_nxt = '0;
        end else begin
            case (state_r)
                SCTS_IDLE: begin
                    if (step_evt && len_r != '0) begin
                        state_nxt = SCTS_CLOSE;
                        idx_nxt = '0;
                    end
                end
                SCTS_OPEN: if (tick && tmr_r == `SCTS_RLY_OPEN_MS - 14'h0001) state_nxt = SCTS_CLOSE;
                SCTS_CLOSE: if (tick && tmr_r == `SCTS_RLY_CLOSE_MS - 14'h0001) state_nxt = SCTS_DELAY;
                SCTS_DELAY: if (tmr_r >= delay_r) state_nxt = SCTS_MADE;
                SCTS_MADE: begin
                    if (step_evt && at_last) begin
                        state_nxt = SCTS_IDLE;
                        idx_nxt = '0;
                    end else if (step_evt) begin
                        state_nxt = SCTS_OPEN;
                        idx_nxt = idx_r + 1'b1;
                    end
                end
                default: state_nxt = SCTS_IDLE;
            endcase
        end
    end

    // Step edges outside the idle and made states fall through the case above
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SCTS_IDLE;
            idx_r <= '0;
            tmr_r <= '0;
        end else begin
            state_r <= state_nxt;
            idx_r <= idx_nxt;
            tmr_r <= st_chg ? 14'h0000 : (tick ? tmr_r + 14'h0001 : tmr_r);
        end
    end

    wire close_nxt = (state_nxt == SCTS_CLOSE) | (state_nxt == SCTS_DELAY) | (state_nxt == SCTS_MADE);
    wire made_start = (state_r == SCTS_DELAY) & (state_nxt == SCTS_MADE);
    wire made_last = tick & (pc_r == pulse_r - 8'h01);
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            relay_r <= 1'b0;
            made_r <= 1'b0;
            pc_r <= '0;
        end else begin
            relay_r <= close_nxt;
            if (made_start) begin
                made_r <= 1'b1;
                pc_r <= '0;
            end else if (state_nxt != SCTS_MADE || made_last) begin
                made_r <= 1'b0;
            end else if (tick) begin
                pc_r <= pc_r + 8'h01;
            end
        end
    end

    assign made_out = made_r;
    assign relay_on = relay_r;
    assign bus_relay_on = relay_r;
    assign scan_active = busy;
    assign relay_chan = mem_rd;

    // While scanning the memory port follows the channel index, otherwise the list pointer
    wire [LIST_AW-1:0] mem_ra = (state_nxt != SCTS_IDLE) ? idx_nxt : laddr_r;

    scts_list_mem #(
        .AW(LIST_AW),
        .DW(CH_W)
    ) u_list (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .we(we_ldata),
        .waddr(laddr_r),
        .wdata(cfg_wd[CH_W-1:0]),
        .raddr(mem_ra),
        .rdata(mem_rd)
    );

    // Register view shared by bus reads and the save walk
    logic [31:0] val [0:15];
    assign val[0] = 32'h0000_0000;
    assign val[1] = {16'(idx_r), 13'h0000, made_r, relay_r, busy};
    assign val[2] = {24'h00_0000, pulse_r};
    assign val[3] = {18'h0_0000, delay_r};
    assign val[4] = {fms_r, 15'h0000, fen_r};
    assign val[5] = {31'h0000_0000, src_r};
    assign val[6] = 32'(len_r);
    assign val[7] = 32'(laddr_r);
    assign val[8] = 32'(mem_rd);
    assign val[9] = comm_r;
    generate
        for (genvar g = 10; g < 16; g++) begin : g_unmapped
            assign val[g] = 32'h0000_0000;
        end
    endgenerate

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= '0;
        end else if (rd_start) begin
            avs_readdata <= val[avs_address];
        end
    end

    // Save walk: pulse, delay, filter, source, length, one per cycle to storage
    wire [3:0] sv_addr = `SCTS_OFS_PULSE + 4'(sv_i_r);
    wire pend_emit = pend_r & ~sv_r;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sv_r <= 1'b0;
            sv_i_r <= '0;
            pend_r <= 1'b0;
        end else begin
            pend_r <= comm_bus | (pend_r & ~pend_emit);
            if (save_cmd && !sv_r) begin
                sv_r <= 1'b1;
                sv_i_r <= '0;
            end else if (sv_r) begin
                sv_r <= (sv_i_r != `SCTS_SAVE_LAST);
                sv_i_r <= sv_i_r + 3'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nv_wr <= 1'b0;
            nv_wr_addr <= '0;
            nv_wr_data <= '0;
        end else begin
            nv_wr <= sv_r | pend_emit;
            nv_wr_addr <= sv_r ? sv_addr : `SCTS_OFS_COMM;
            nv_wr_data <= sv_r ? val[sv_addr] : comm_r;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    AST_START: assert property (state_r == SCTS_IDLE && step_evt && len_r != '0 && !abort_evt
        |=> state_r == SCTS_CLOSE && relay_on) else $error("scan did not start");
    AST_IGNORE: assert property (state_r != SCTS_MADE && state_r != SCTS_IDLE && !abort_evt
        |=> $stable(idx_r)) else $error("step taken during switch");
    AST_ABORT: assert property (abort_evt |=> state_r == SCTS_IDLE && !relay_on && !made_out)
        else $error("abort left relay closed");
    AST_PULSE_ON: assert property (made_start |=> made_out) else $error("no made pulse");
    AST_PULSE_OFF: assert property (made_out && state_nxt != SCTS_MADE |=> !made_out)
        else $error("made pulse outlived relay");
    AST_INIT: assert property (init_cmd |=> pulse_r == `SCTS_PULSE_RST && len_r == '0 && !fen_r
        && !relay_on && !made_out) else $error("init defaults wrong");
    AST_CLAMP: assert property (pulse_r >= 8'h01 && pulse_r <= 8'h64)
        else $error("pulse width out of range");
    AST_WRAP: assert property (state_r == SCTS_MADE && step_evt && at_last && !abort_evt
        |=> state_r == SCTS_IDLE && idx_r == '0) else $error("last step did not end scan");
    AST_COMM: assert property (comm_bus |-> ##[1:8] (nv_wr && nv_wr_addr == 4'h9))
        else $error("communication setting not stored");
    AST_SAVE: assert property (nv_wr && nv_wr_addr != 4'h9 |-> $past(sv_r))
        else $error("saveable stored without save");
    AST_TICK: assert property (made_start |=> made_out ##1 (made_out || state_r != SCTS_MADE))
        else $error("made pulse too short");

    COV_START: cover property (state_r == SCTS_IDLE ##1 state_r == SCTS_CLOSE);
    COV_WRAP: cover property (state_r == SCTS_MADE && step_evt && at_last);
    COV_ABORT: cover property (state_r == SCTS_MADE && abort_evt);
    COV_SAVE: cover property (save_cmd ##5 nv_wr);
endmodule

/* src/scts_cfg.svh */
`ifndef SCTS_CFG_SVH
`define SCTS_CFG_SVH
// Register word indices
`define SCTS_OFS_CTRL 4'h0
`define SCTS_OFS_STAT 4'h1
`define SCTS_OFS_PULSE 4'h2
`define SCTS_OFS_DELAY 4'h3
`define SCTS_OFS_FILT 4'h4
`define SCTS_OFS_SRC 4'h5
`define SCTS_OFS_LEN 4'h6
`define SCTS_OFS_LADDR 4'h7
`define SCTS_OFS_LDATA 4'h8
`define SCTS_OFS_COMM 4'h9
// Control command bits
`define SCTS_CTRL_TRG 0
`define SCTS_CTRL_ABORT 1
`define SCTS_CTRL_INIT 2
`define SCTS_CTRL_SAVE 3
// Filter register fields
`define SCTS_FILT_EN 0
`define SCTS_FILT_MS_LSB 16
// Defaults and limits, in ms where timed
`define SCTS_PULSE_RST 8'h05
`define SCTS_PULSE_MIN 8'h01
`define SCTS_PULSE_MAX 8'h64
`define SCTS_DELAY_RST 14'h0000
`define SCTS_DELAY_MAX 14'h270F
`define SCTS_FILT_MS_RST 16'h0032
`define SCTS_FILT_EN_RST 1'h0
`define SCTS_SRC_STEP 1'h0
`define SCTS_COMM_RST 32'h0000_2580
// Relay settle times
`define SCTS_RLY_OPEN_MS 14'h0005
`define SCTS_RLY_CLOSE_MS 14'h0005
// Timebase
`define SCTS_CLK_NS 100
`define SCTS_TICK_NS 1000000
`define SCTS_TICK_CYC (`SCTS_TICK_NS / `SCTS_CLK_NS)
// Index of the last saveable register walked by a save (five in all)
`define SCTS_SAVE_LAST 3'h4
`endif

/* src/scts_pkg.sv */
package scts_pkg;
    typedef enum logic [2:0] {
        SCTS_IDLE,
        SCTS_OPEN,
        SCTS_CLOSE,
        SCTS_DELAY,
        SCTS_MADE
    } scts_state_t;
endpackage

/* src/scts_list_mem.sv */
`timescale 1ns/1ps
module scts_list_mem #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    always_ff @(posedge core_clk) begin
        if (we) begin
            mem_r[waddr] <= wdata;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= '0;
        end else begin
            rdata <= mem_r[raddr];
        end
    end
endmodule

/* tb/scts_ext_ctl.sv */
`timescale 1ns/1ps
module scts_ext_ctl #(
    parameter int TICK_CYC = 10
) (
    input wire logic core_clk,
    input wire logic made_out,
    output logic step_in,
    output logic abort_in
);
    initial begin
        step_in = 1'b0;
        abort_in = 1'b0;
    end
    // Held past one tick so the input filter and synchroniser cannot miss it
    task automatic pulse(input bit abrt, input int lag);
        repeat (lag) @(posedge core_clk);
        if (abrt) begin
            abort_in <= 1'b1;
        end else begin
            step_in <= 1'b1;
        end
        repeat (TICK_CYC + 2) @(posedge core_clk);
        step_in <= 1'b0;
        abort_in <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wait_made(input bit level, output bit seen);
        seen = 1'b0;
        for (int i = 0; i < 4000 && !seen; i++) begin
            @(posedge core_clk);
            seen = (made_out === level);
        end
    endtask
endmodule

/* tb/scan_trigger_sequencer_tb_top.sv */
`timescale 1ns/1ps
module scan_trigger_sequencer_tb_top;
    localparam int TICK = 10;
    localparam int PW = 2;
    logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic step_in, abort_in, made_out, relay_on, bus_relay_on, scan_active, nv_wr;
    logic [15:0] relay_chan;
    logic [15:0] mch;
    logic [3:0] nv_wr_addr;
    logic [31:0] nv_wr_data;
    logic [31:0] rdq[$];
    logic [35:0] nvq[$];
    logic [16:0] mq[$];
    logic [16:0] m;
    logic [15:0] chan[3];
    logic [31:0] pw_in[3] = '{32'h0000_00C8, 32'h0000_0000, 32'h0000_0002};
    logic [31:0] pw_out[3] = '{32'h0000_0064, 32'h0000_0001, 32'h0000_0002};
    logic [31:0] rng = 32'h0000_003F;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int mlen = 0;
    bit seen;

    scts_sequencer #(.TICK_CYC(TICK)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .step_in(step_in), .abort_in(abort_in), .made_out(made_out),
        .relay_on(relay_on), .relay_chan(relay_chan), .bus_relay_on(bus_relay_on), .scan_active(scan_active),
        .nv_wr(nv_wr), .nv_wr_addr(nv_wr_addr), .nv_wr_data(nv_wr_data), .nv_ld(1'b0),
        .nv_ld_addr(4'h0), .nv_ld_data(32'h0000_0000)
    );
    scts_ext_ctl #(.TICK_CYC(TICK)) ctl (
        .core_clk(core_clk), .made_out(made_out), .step_in(step_in), .abort_in(abort_in)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    task automatic complete_run();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; for reads d is the expected word
    task automatic bus(input logic [3:0] a, input bit wr, input logic [31:0] d);
        int n;
        avs_address <= a;
        avs_writedata <= wr ? d : 32'h0000_0000;
        if (wr) begin
            avs_write <= 1'b1;
        end else begin
            avs_read <= 1'b1;
            rdq.push_back(d);
        end
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) n_mismatch++;
        // Extra edge so a following call never re-drives the strobe in the same step
        @(posedge core_clk);
    endtask

    task automatic wm(input bit level);
        ctl.wait_made(level, seen);
        if (!seen) cmp("made_level_wait", 1, 0);
    endtask

    always @(negedge core_clk) begin
        if (nv_wr === 1'b1) cmp("nv_store", nvq.pop_front(), {nv_wr_addr, nv_wr_data});
        if (scan_active === 1'b0) cmp("idle_relays_open", 2'b00, {relay_on, bus_relay_on});
        if (made_out === 1'b1) begin
            if (mlen == 0) begin
                mch = relay_chan;
                cmp("made_relays_closed", 3'b111, {relay_on, bus_relay_on, scan_active});
            end
            mlen++;
        end else if (mlen != 0) begin
            m = mq.pop_front();
            cmp("made_chan", m[16:1], mch);
            cmp("made_full_width", m[0], mlen == PW * TICK);
            mlen = 0;
        end
    end

    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp("readdata", rdq.pop_front(), avs_readdata);
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        sys_rst = 1'b1;
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(4'h2, 0, 32'h0000_0005);
        bus(4'h3, 0, 32'h0000_0000);
        bus(4'h5, 0, 32'h0000_0000);
        bus(4'h6, 0, 32'h0000_0000);
        bus(4'h4, 0, 32'h0032_0000);
        bus(4'h1, 0, 32'h0000_0000);
        bus(4'hA, 0, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            bus(4'h2, 1, pw_in[i]);
            bus(4'h2, 0, pw_out[i]);
        end
        bus(4'h7, 1, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            rng = xs(rng);
            chan[i] = rng[15:0];
            bus(4'h8, 1, {16'h0000, chan[i]});
        end
        bus(4'h6, 1, 32'h0000_0003);
        bus(4'h7, 1, 32'h0000_0000);
        bus(4'h8, 0, {16'h0000, chan[0]});
        // Save walks the saveable words in order
        nvq = '{{4'h2, 32'h0000_0002}, {4'h3, 32'h0000_0000}, {4'h4, 32'h0032_0000},
                {4'h5, 32'h0000_0000}, {4'h6, 32'h0000_0003}};
        bus(4'h0, 1, 32'h0000_0008);
        repeat (20) @(posedge core_clk);
        nvq.push_back({4'h9, 32'h0000_4B00});
        bus(4'h9, 1, 32'h0000_4B00);
        bus(4'h3, 1, 32'h0000_0003);
        repeat (20) @(posedge core_clk);
        // First pulse is cut short by a step while it is high
        mq.push_back({chan[0], 1'b0});
        ctl.pulse(0, 0);
        ctl.pulse(0, 10);
        wm(1);
        ctl.pulse(0, 5);
        mq.push_back({chan[1], 1'b1});
        wm(1);
        wm(0);
        bus(4'h2, 1, 32'h0000_0007);
        mq.push_back({chan[2], 1'b1});
        ctl.pulse(0, 0);
        wm(1);
        wm(0);
        ctl.pulse(0, 0);
        repeat (80) @(posedge core_clk);
        bus(4'h1, 0, 32'h0000_0000);
        bus(4'h2, 0, 32'h0000_0002);
        mq.push_back({chan[0], 1'b1});
        ctl.pulse(0, 0);
        wm(1);
        wm(0);
        ctl.pulse(1, 0);
        repeat (10) @(posedge core_clk);
        bus(4'h1, 0, 32'h0000_0000);
        mq.push_back({chan[0], 1'b1});
        bus(4'h0, 1, 32'h0000_0001);
        wm(1);
        wm(0);
        bus(4'h0, 1, 32'h0000_0004);
        repeat (10) @(posedge core_clk);
        bus(4'h1, 0, 32'h0000_0000);
        bus(4'h2, 0, 32'h0000_0005);
        bus(4'h6, 0, 32'h0000_0000);
        bus(4'h3, 0, 32'h0000_0000);
        bus(4'h4, 0, 32'h0032_0000);
        bus(4'h9, 0, 32'h0000_4B00);
        // Empty list: a step must not start anything
        ctl.pulse(0, 0);
        repeat (80) @(posedge core_clk);
        bus(4'h1, 0, 32'h0000_0000);
        repeat (5) @(posedge core_clk);
        cmp("queues_drained", 0, rdq.size() + nvq.size() + mq.size());
        complete_run();
    end
endmodule
